// ===== src/rf_freq_map.svh
// offsets, field positions, reset values and scale figures of the frequency register bank
`ifndef RF_FREQ_MAP_SVH
`define RF_FREQ_MAP_SVH

`define ADDR_FREQ_OFFSET_LOW      7'h73
`define ADDR_FREQ_OFFSET_HIGH     7'h74
`define ADDR_BAND_SELECT          7'h75
`define ADDR_CARRIER_WORD_HIGH    7'h76
`define ADDR_CARRIER_WORD_LOW     7'h77
`define ADDR_MISC_SETTINGS        7'h78
`define ADDR_HOP_CHANNEL          7'h79
`define ADDR_HOP_STEP             7'h7A
`define ADDR_TURNAROUND_LENGTH    7'h7B

`define RST_FREQ_OFFSET_LOW       8'h00
`define RST_FREQ_OFFSET_HIGH      8'h00
`define RST_BAND_SELECT           8'h75
`define RST_CARRIER_WORD_HIGH     8'hBB
`define RST_CARRIER_WORD_LOW      8'h80
`define RST_MISC_SETTINGS         8'h00
`define RST_HOP_CHANNEL           8'h00
`define RST_HOP_STEP              8'h00
`define RST_TURNAROUND_LENGTH     8'h7B

`define FO_HIGH_WRITE_MASK        8'h03
`define BAND_WRITE_MASK           8'h7F
`define BAND_INDEX_MSB            4
`define BAND_SIDEBAND_BIT         6
`define BAND_900_INDEX            5'h15
`define BAND_920_INDEX            5'h16
`define BAND_940_INDEX            5'h17
`define MISC_ALT_AMP_BIT          3
`define MISC_RCOSC_MSB            2
`define TURN_LENGTH_BIT           7
`define TURN_ENABLE_BIT           2
`define TURN_PHASE_MSB            1
`define TURN_POS_BASE             3'h4

`define CARRIER_BAND_BIAS         24
`define CARRIER_WORD_DIVISOR      64000
`define CARRIER_BAND_KHZ          10000
`define CARRIER_BAND_MULT         2
`define HOP_STEP_KHZ              10
`define CARRIER_FRAC              16

`endif

// ===== src/rf_freq_pkg.sv
// types shared by the frequency register bank
package rf_freq_pkg;
	typedef enum logic [1:0] {
		BAND_OTHER,
		BAND_900,
		BAND_920,
		BAND_940
	} band_range_t;

	typedef logic [7:0] reg_byte_t;
endpackage

// ===== src/carrier_calc.sv
// carrier frequency arithmetic, result in sixteenths of a kHz
`timescale 1ns/1ps
`default_nettype none
`include "rf_freq_map.svh"

module carrier_calc
(
	input  wire logic        clock,          // system clock
	input  wire logic        rst,            // synchronous reset
	input  wire logic [4:0]  band_index,     // 20 MHz band number
	input  wire logic [15:0] nominal_word,   // nominal carrier word
	input  wire logic [9:0]  freq_offset,    // two's complement offset
	input  wire logic [7:0]  hop_channel,    // hop channel number
	input  wire logic [7:0]  hop_step,       // hop step, 10 kHz units
	output logic      [31:0] carrier_khz_x16 // carrier in kHz/16
);
	// scaled by 16 so the 312.5 Hz offset step stays exact
	localparam logic signed [33:0] BAND_BIAS = 34'(`CARRIER_BAND_BIAS);
	localparam logic signed [33:0] BAND_K    =
		34'(`CARRIER_BAND_KHZ * `CARRIER_BAND_MULT * `CARRIER_FRAC);
	localparam logic signed [33:0] WORD_K    = 34'(
		(`CARRIER_BAND_KHZ * `CARRIER_BAND_MULT * `CARRIER_FRAC) / `CARRIER_WORD_DIVISOR);
	localparam logic signed [33:0] HOP_K     = 34'(`HOP_STEP_KHZ * `CARRIER_FRAC);

	logic signed [33:0] band_term;
	logic signed [33:0] word_term;
	logic signed [33:0] hop_term;
	logic signed [33:0] next_sum;

	always_comb
	begin
		band_term = ($signed({29'h0, band_index}) + BAND_BIAS) * BAND_K;
		word_term = ($signed({18'h0, nominal_word})
			+ $signed({{24{freq_offset[9]}}, freq_offset})) * WORD_K;
		hop_term  = $signed({26'h0, hop_channel}) * $signed({26'h0, hop_step}) * HOP_K;
		next_sum  = band_term + word_term + hop_term;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			carrier_khz_x16 <= 32'h0;
		else
			carrier_khz_x16 <= next_sum[31:0];
	end
endmodule
`default_nettype wire

// ===== src/turnaround_point.sv
// one pulse at the chosen bit of the last byte for the rx/tx frequency switch
`timescale 1ns/1ps
`default_nettype none
`include "rf_freq_map.svh"

module turnaround_point
(
	input  wire logic       clock,        // system clock
	input  wire logic       rst,          // synchronous reset
	input  wire logic       enable,       // turn-around switch enabled
	input  wire logic [1:0] phase,        // bit position select
	input  wire logic       last_byte,    // last byte of packet in flight
	input  wire logic [2:0] bit_index,    // bit within the current byte
	output logic            shift_pulse   // one-cycle switch request
);
	logic       fired;
	logic [2:0] position;

	assign position = `TURN_POS_BASE | {1'b0, phase};

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			shift_pulse <= 1'b0;
			fired       <= 1'b0;
		end
		else
		begin
			// fire once per last byte, re-armed when the byte ends
			shift_pulse <= enable && last_byte && !fired && (bit_index == position);
			if (!last_byte)
				fired <= 1'b0;
			else if (enable && bit_index == position)
				fired <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== src/rf_frequency_control_regs.sv
// carrier frequency register bank with derived synthesizer settings
`timescale 1ns/1ps
`default_nettype none
`include "rf_freq_map.svh"

module rf_frequency_control_regs
	import rf_freq_pkg::*;
#(
	parameter int unsigned CRC_WIDTH = 3
)
(
	input  wire logic                 clock,                    // 100 MHz system clock
	input  wire logic                 rst,                      // synchronous reset
	input  wire logic [6:0]           reg_addr,                 // register address
	input  wire logic                 reg_wr,                   // write strobe
	input  wire logic [7:0]           reg_wdata,                // write data
	input  wire logic                 reg_rd,                   // read strobe
	output logic      [7:0]           reg_rdata,                // read data
	output logic                      reg_rvalid,               // read data valid pulse
	input  wire logic [9:0]           afc_result,               // correction from modem
	input  wire logic                 afc_valid,                // new correction strobe
	input  wire logic                 last_byte,                // last packet byte in flight
	input  wire logic [2:0]           bit_index,                // bit within current byte
	input  wire logic [7:0]           pkt_length,               // length field of packet
	input  wire logic [CRC_WIDTH-1:0] crc_length,               // crc bytes in use
	output logic      [31:0]          carrier_khz_x16,          // carrier in kHz/16
	output logic      [9:0]           freq_offset,              // programmed offset
	output logic      [4:0]           band_index,               // band number
	output logic                      sideband_select,          // sideband choice
	output band_range_t               band_range,               // decoded band range
	output logic      [15:0]          nominal_carrier_word,     // nominal word
	output logic      [7:0]           hop_channel_number,       // hop channel
	output logic      [7:0]           hop_step_size,            // hop step
	output logic                      alternate_amp_sequencing, // alternate amp order
	output logic      [2:0]           rcosc_trim,               // oscillator trim
	output logic                      length_includes_crc,      // length counts crc
	output logic      [7:0]           payload_length,           // payload bytes only
	output logic      [8:0]           frame_length,             // payload plus crc
	output logic                      turnaround_shift          // frequency switch pulse
);
	reg_byte_t freq_offset_low;
	reg_byte_t freq_offset_high;
	reg_byte_t band_select;
	reg_byte_t carrier_word_high;
	reg_byte_t carrier_word_low;
	reg_byte_t misc_settings;
	reg_byte_t hop_channel;
	reg_byte_t hop_step;
	reg_byte_t turnaround_length_ctrl;
	logic [9:0] afc_latest;
	reg_byte_t  next_rdata;
	logic       hit;
	logic       sel_offset_low;
	logic       sel_offset_high;
	logic       sel_band;
	logic       sel_word_high;
	logic       sel_word_low;
	logic       sel_misc;
	logic       sel_hop_channel;
	logic       sel_hop_step;
	logic       sel_turnaround;
	logic [7:0] next_payload;
	logic [8:0] next_frame;
	logic [8:0] crc_ext;

	// one-hot write select; unmapped addresses select nothing
	always_comb
	begin
		sel_offset_low  = 1'b0;
		sel_offset_high = 1'b0;
		sel_band        = 1'b0;
		sel_word_high   = 1'b0;
		sel_word_low    = 1'b0;
		sel_misc        = 1'b0;
		sel_hop_channel = 1'b0;
		sel_hop_step    = 1'b0;
		sel_turnaround  = 1'b0;
		if (reg_wr)
		begin
			case (reg_addr)
				`ADDR_FREQ_OFFSET_LOW:   sel_offset_low  = 1'b1;
				`ADDR_FREQ_OFFSET_HIGH:  sel_offset_high = 1'b1;
				`ADDR_BAND_SELECT:       sel_band        = 1'b1;
				`ADDR_CARRIER_WORD_HIGH: sel_word_high   = 1'b1;
				`ADDR_CARRIER_WORD_LOW:  sel_word_low    = 1'b1;
				`ADDR_MISC_SETTINGS:     sel_misc        = 1'b1;
				`ADDR_HOP_CHANNEL:       sel_hop_channel = 1'b1;
				`ADDR_HOP_STEP:          sel_hop_step    = 1'b1;
				`ADDR_TURNAROUND_LENGTH: sel_turnaround  = 1'b1;
				default:                 sel_offset_low  = 1'b0;
			endcase
		end
	end

	// host copy of the offset; reads show the correction instead
	always_ff @(posedge clock)
	begin
		if (rst)
			freq_offset_low <= `RST_FREQ_OFFSET_LOW;
		else if (sel_offset_low)
			freq_offset_low <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			freq_offset_high <= `RST_FREQ_OFFSET_HIGH;
		else if (sel_offset_high)
			freq_offset_high <= reg_wdata & `FO_HIGH_WRITE_MASK;
	end

	// bit 5 kept as written; the host is expected to keep it set
	always_ff @(posedge clock)
	begin
		if (rst)
			band_select <= `RST_BAND_SELECT;
		else if (sel_band)
			band_select <= reg_wdata & `BAND_WRITE_MASK;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			carrier_word_high <= `RST_CARRIER_WORD_HIGH;
		else if (sel_word_high)
			carrier_word_high <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			carrier_word_low <= `RST_CARRIER_WORD_LOW;
		else if (sel_word_low)
			carrier_word_low <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			misc_settings <= `RST_MISC_SETTINGS;
		else if (sel_misc)
			misc_settings <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			hop_channel <= `RST_HOP_CHANNEL;
		else if (sel_hop_channel)
			hop_channel <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			hop_step <= `RST_HOP_STEP;
		else if (sel_hop_step)
			hop_step <= reg_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			turnaround_length_ctrl <= `RST_TURNAROUND_LENGTH;
		else if (sel_turnaround)
			turnaround_length_ctrl <= reg_wdata;
	end

	// latest correction result, held until the modem reports another
	always_ff @(posedge clock)
	begin
		if (rst)
			afc_latest <= 10'h000;
		else if (afc_valid)
			afc_latest <= afc_result;
	end

	// read decode: offset reads show the correction, never the written value
	always_comb
	begin
		hit        = 1'b1;
		next_rdata = 8'h00;
		case (reg_addr)
			`ADDR_FREQ_OFFSET_LOW:   next_rdata = afc_latest[7:0];
			`ADDR_FREQ_OFFSET_HIGH:  next_rdata = {6'h00, afc_latest[9:8]};
			`ADDR_BAND_SELECT:       next_rdata = band_select & `BAND_WRITE_MASK;
			`ADDR_CARRIER_WORD_HIGH: next_rdata = carrier_word_high;
			`ADDR_CARRIER_WORD_LOW:  next_rdata = carrier_word_low;
			`ADDR_MISC_SETTINGS:     next_rdata = misc_settings;
			`ADDR_HOP_CHANNEL:       next_rdata = hop_channel;
			`ADDR_HOP_STEP:          next_rdata = hop_step;
			`ADDR_TURNAROUND_LENGTH: next_rdata = turnaround_length_ctrl;
			default:                 hit        = 1'b0;
		endcase
	end

	// reads change no state; unmapped addresses answer zero
	always_ff @(posedge clock)
	begin
		if (rst)
			reg_rvalid <= 1'b0;
		else
			reg_rvalid <= reg_rd;
	end

	// data holds until the next read so a slow host can still take it
	always_ff @(posedge clock)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= hit ? next_rdata : 8'h00;
	end

	// field outputs are wires from the register flops
	assign freq_offset          = {freq_offset_high[1:0], freq_offset_low};
	assign band_index           = band_select[`BAND_INDEX_MSB:0];
	assign sideband_select      = band_select[`BAND_SIDEBAND_BIT];
	assign nominal_carrier_word = {carrier_word_high, carrier_word_low};
	assign hop_channel_number   = hop_channel;
	assign hop_step_size        = hop_step;
	assign alternate_amp_sequencing = misc_settings[`MISC_ALT_AMP_BIT];
	assign rcosc_trim           = misc_settings[`MISC_RCOSC_MSB:0];
	assign length_includes_crc  = turnaround_length_ctrl[`TURN_LENGTH_BIT];

	// band range decode registered to keep the output on a flop
	always_ff @(posedge clock)
	begin
		if (rst)
			band_range <= BAND_OTHER;
		else
		begin
			case (band_select[`BAND_INDEX_MSB:0])
				`BAND_900_INDEX: band_range <= BAND_900;
				`BAND_920_INDEX: band_range <= BAND_920;
				`BAND_940_INDEX: band_range <= BAND_940;
				default:         band_range <= BAND_OTHER;
			endcase
		end
	end

	// length accounting; crc itself is enabled elsewhere
	assign crc_ext = 9'(crc_length);

	always_comb
	begin
		if (turnaround_length_ctrl[`TURN_LENGTH_BIT])
		begin
			// length already counts crc; saturate rather than wrap on a short field
			next_payload = ({1'b0, pkt_length} > crc_ext)
				? 8'({1'b0, pkt_length} - crc_ext) : 8'h00;
			next_frame   = {1'b0, pkt_length};
		end
		else
		begin
			next_payload = pkt_length;
			next_frame   = {1'b0, pkt_length} + crc_ext;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			payload_length <= 8'h00;
		else
			payload_length <= next_payload;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			frame_length <= 9'h000;
		else
			frame_length <= next_frame;
	end

	carrier_calc u_carrier_calc
	(
		.clock           (clock),
		.rst             (rst),
		.band_index      (band_select[`BAND_INDEX_MSB:0]),
		.nominal_word    ({carrier_word_high, carrier_word_low}),
		.freq_offset     ({freq_offset_high[1:0], freq_offset_low}),
		.hop_channel     (hop_channel),
		.hop_step        (hop_step),
		.carrier_khz_x16 (carrier_khz_x16)
	);

	// the host must pick a phase late enough; no guard here
	turnaround_point u_turnaround_point
	(
		.clock       (clock),
		.rst         (rst),
		.enable      (turnaround_length_ctrl[`TURN_ENABLE_BIT]),
		.phase       (turnaround_length_ctrl[`TURN_PHASE_MSB:0]),
		.last_byte   (last_byte),
		.bit_index   (bit_index),
		.shift_pulse (turnaround_shift)
	);
endmodule
`default_nettype wire

// ===== test/rf_freq_regs_assertions.sv
// port-level checker for the frequency register bank
`timescale 1ns/1ps
`default_nettype none
`include "rf_freq_map.svh"

module rf_freq_regs_checker
	import rf_freq_pkg::*;
(
	input wire logic        clock,                // clock
	input wire logic        rst,                  // reset
	input wire logic [6:0]  reg_addr,             // address
	input wire logic        reg_wr,               // write
	input wire logic [7:0]  reg_wdata,            // wdata
	input wire logic        reg_rd,               // read
	input wire logic        reg_rvalid,           // read ack
	input wire logic        last_byte,            // last byte
	input wire logic [2:0]  bit_index,            // bit number
	input wire logic [31:0] carrier_khz_x16,      // carrier
	input wire logic [9:0]  freq_offset,          // offset
	input wire logic [4:0]  band_index,           // band
	input wire band_range_t band_range,           // band range
	input wire logic [15:0] nominal_carrier_word, // word
	input wire logic [7:0]  hop_channel_number,   // hop channel
	input wire logic [7:0]  hop_step_size,        // hop step
	input wire logic        turnaround_shift      // switch pulse
);
	int          expv;
	band_range_t exp_range;

	// carrier from the settings of this cycle, in sixteenths of a kHz
	assign expv = (int'(band_index) + 24) * 320000
		+ (int'(nominal_carrier_word) + int'($signed(freq_offset))) * 5
		+ int'(hop_channel_number) * int'(hop_step_size) * 160;
	assign exp_range = (band_index == 5'h15) ? BAND_900 : (band_index == 5'h16) ? BAND_920 :
		(band_index == 5'h17) ? BAND_940 : BAND_OTHER;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_READ_ACK: assert property (!$past(rst) |-> reg_rvalid == $past(reg_rd))
		else $error("read acknowledge does not follow the read strobe");
	AST_BAND_WRITE: assert property (reg_wr && reg_addr == `ADDR_BAND_SELECT |=>
		band_index == $past(reg_wdata[4:0])) else $error("band index not taken from write");
	AST_BAND_RANGE: assert property (!$past(rst) |-> band_range == $past(exp_range))
		else $error("band range decode wrong");
	AST_WORD_HIGH: assert property (reg_wr && reg_addr == `ADDR_CARRIER_WORD_HIGH |=>
		nominal_carrier_word[15:8] == $past(reg_wdata)) else $error("word high byte wrong");
	AST_WORD_LOW: assert property (reg_wr && reg_addr == `ADDR_CARRIER_WORD_LOW |=>
		nominal_carrier_word[7:0] == $past(reg_wdata)) else $error("word low byte wrong");
	AST_OFFSET_HIGH: assert property (reg_wr && reg_addr == `ADDR_FREQ_OFFSET_HIGH |=>
		freq_offset[9:8] == $past(reg_wdata[1:0])) else $error("offset top bits wrong");
	AST_CARRIER: assert property (!$past(rst) |-> carrier_khz_x16 == $past(expv))
		else $error("carrier does not match settings");
	AST_SHIFT_CAUSE: assert property (turnaround_shift |->
		$past(last_byte) && $past(bit_index[2])) else $error("switch pulse without cause");
	AST_SHIFT_SINGLE: assert property (turnaround_shift |=> !turnaround_shift)
		else $error("switch pulse longer than one cycle");

	cover property (reg_wr && reg_addr == `ADDR_BAND_SELECT);
	cover property (turnaround_shift);
	cover property (reg_rvalid);
endmodule

bind rf_frequency_control_regs rf_freq_regs_checker freq_checker (.clock, .rst, .reg_addr,
	.reg_wr, .reg_wdata, .reg_rd, .reg_rvalid, .last_byte, .bit_index, .carrier_khz_x16,
	.freq_offset, .band_index, .band_range, .nominal_carrier_word, .hop_channel_number,
	.hop_step_size, .turnaround_shift);
`default_nettype wire

// ===== test/rf_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
`include "rf_freq_map.svh"

module rf_host_model
(
	input  wire logic       clock,      // clock
	input  wire logic [7:0] reg_rdata,  // read data
	input  wire logic       reg_rvalid, // read ack
	output var logic  [6:0] reg_addr,   // address
	output var logic        reg_wr,     // write strobe
	output var logic  [7:0] reg_wdata,  // write data
	output var logic        reg_rd      // read strobe
);
	initial
	begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == `ADDR_BAND_SELECT)
			v[5] = 1'b1;
		if (a == `ADDR_MISC_SETTINGS)
			v[2:0] = 3'h0; // trim stays at its reset value
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~v; // no stale data left on the bus
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		ok = (reg_rvalid === 1'b1);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== test/tb_rf_frequency_control_regs.sv
// self-checking bench for the frequency register bank
`timescale 1ns/1ps
`default_nettype none

module tb_rf_frequency_control_regs
	import rf_freq_pkg::*;
;
	logic        clock, rst, reg_wr, reg_rd, reg_rvalid, afc_valid, last_byte;
	logic        sideband_select, alternate_amp_sequencing, length_includes_crc;
	logic        turnaround_shift;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, pkt_length, hop_channel_number, hop_step_size;
	logic [7:0]  payload_length;
	logic [9:0]  afc_result, freq_offset;
	logic [2:0]  bit_index, crc_length, rcosc_trim;
	logic [4:0]  band_index;
	logic [15:0] nominal_carrier_word;
	logic [8:0]  frame_length;
	logic [31:0] carrier_khz_x16;
	band_range_t band_range;
	int          failures = 0;
	int          checks_done = 0;
	localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h75, 8'hBB, 8'h80, 8'h00, 8'h00,
		8'h00, 8'h7B};
	localparam logic [6:0] WA [9] = '{7'h76, 7'h77, 7'h79, 7'h7A, 7'h78, 7'h7B, 7'h75,
		7'h7F, 7'h74};
	localparam logic [7:0] WD [9] = '{8'h12, 8'h34, 8'h05, 8'h0A, 8'hF8, 8'h87, 8'hD7,
		8'hAB, 8'hFF};
	localparam logic [7:0] WE [9] = '{8'h12, 8'h34, 8'h05, 8'h0A, 8'hF8, 8'h87, 8'h77,
		8'h00, 8'h00};

	rf_frequency_control_regs #(.CRC_WIDTH(3)) DUT (.clock, .rst, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .afc_result, .afc_valid, .last_byte,
		.bit_index, .pkt_length, .crc_length, .carrier_khz_x16, .freq_offset, .band_index,
		.sideband_select, .band_range, .nominal_carrier_word, .hop_channel_number,
		.hop_step_size, .alternate_amp_sequencing, .rcosc_trim, .length_includes_crc,
		.payload_length, .frame_length, .turnaround_shift);
	rf_host_model host (.clock, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd);

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_read(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host.rd(a, d, ok);
		check_word({31'h0, ok}, 32'h1);
		check_word({24'h0, d}, {24'h0, exp});
	endtask

	// walks bit 0..7 with last_byte held high and records where the pulse appears
	task automatic sweep(input logic [31:0] n_exp, input logic [31:0] at_exp);
		int pulses;
		int at;
		pulses = 0;
		at = 0;
		for (int b = 0; b < 10; b++)
		begin
			@(posedge clock);
			#1;
			if (turnaround_shift === 1'b1)
			begin
				pulses++;
				at = b;
			end
			last_byte = 1'b1;
			bit_index = (b < 8) ? 3'(b) : 3'h0;
		end
		check_word(32'(pulses), n_exp);
		check_word(32'(at), at_exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		rst = 1'b1;
		afc_result = 10'h000;
		afc_valid = 1'b0;
		last_byte = 1'b0;
		bit_index = 3'h0;
		pkt_length = 8'h00;
		crc_length = 3'h0;
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 9; i++)
			check_read(7'(7'h73 + i), RV[i]);
		check_word(carrier_khz_x16, 32'((21 + 24) * 320000 + 48000 * 5));
		check_word(32'(band_range), 32'(BAND_900));
		$display("test reset values done");
		for (int i = 0; i < 9; i++)
		begin
			host.wr(WA[i], WD[i]);
			check_read(WA[i], WE[i]);
		end
		host.wr(7'h73, 8'hF0);
		check_read(7'h73, 8'h00);
		settle();
		check_word(32'(freq_offset), 32'h3F0);
		check_word(carrier_khz_x16, 32'(47 * 320000 + (4660 - 16) * 5 + 50 * 160));
		check_word(32'(band_range), 32'(BAND_940));
		check_word({29'h0, sideband_select, alternate_amp_sequencing, 1'b0}, 32'h6);
		check_word(32'(rcosc_trim), 32'h0);
		check_word({16'h0, nominal_carrier_word}, 32'h0000_1234);
		check_word({16'h0, hop_channel_number, hop_step_size}, 32'h0000_050A);
		check_word({26'h0, length_includes_crc, band_index}, 32'h0000_0037);
		$display("test write and read-back done");
		afc_result = 10'h2A5;
		afc_valid = 1'b1;
		@(posedge clock);
		#1;
		afc_valid = 1'b0;
		afc_result = 10'h15A;
		check_read(7'h73, 8'hA5);
		check_read(7'h74, 8'h02);
		check_word(32'(freq_offset), 32'h3F0);
		$display("test correction read-back done");
		crc_length = 3'h2;
		pkt_length = 8'h09;
		settle();
		check_word({15'h0, frame_length, payload_length}, 32'h0000_0907);
		pkt_length = 8'h01;
		settle();
		check_word(32'(payload_length), 32'h0);
		// crc turn-on sits outside this bank; late phase keeps final bits
		host.wr(7'h7B, 8'h07);
		pkt_length = 8'h09;
		settle();
		check_word({15'h0, frame_length, payload_length}, 32'h0000_0B09);
		$display("test length accounting done");
		sweep(1, 8);
		sweep(0, 0);
		last_byte = 1'b0;
		host.wr(7'h7B, 8'h04);
		sweep(1, 5);
		last_byte = 1'b0;
		host.wr(7'h7B, 8'h05);
		sweep(1, 6);
		last_byte = 1'b0;
		host.wr(7'h7B, 8'h06);
		sweep(1, 7);
		last_byte = 1'b0;
		host.wr(7'h7B, 8'h03);
		sweep(0, 0);
		$display("test turn-around done");
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		check_read(7'h75, 8'h75);
		check_word(32'(alternate_amp_sequencing), 32'h0);
		check_word(32'(length_includes_crc), 32'h0);
		$display("test mid-run reset done");
		conclude();
	end
endmodule
`default_nettype wire
